// ==== src/bopm_pkg.sv ====
// Purpose: Shared constants and decode functions for the boot option and program map block
// Assumes: 16-bit program addresses, option bytes fetched one byte per flash read
// Notes:   Register offsets are byte addresses on a 32-bit AHB-Lite bus
package bopm_pkg;
    // ==========================================================
    // Program map
    localparam logic [15:0] BOPM_VEC_AREA_LAST = 16'h00ff;
    localparam logic [15:0] BOPM_DEFAULT_VEC = 16'h0100;
    localparam logic [15:0] BOPM_ISP_START = 16'h0100;
    localparam logic [15:0] BOPM_OPT_ADDR_LO = 16'h003c;
    localparam logic [15:0] BOPM_OPT_ADDR_3E = 16'h003e;
    localparam logic [15:0] BOPM_OPT_ADDR_3F = 16'h003f;
    localparam logic [15:0] BOPM_FLASH_BYTES = 16'h4000;
    // ==========================================================
    // Option byte fields
    localparam int BOPM_ISP_OFF_BIT = 7;
    localparam int BOPM_VSEL_HI = 6;
    localparam int BOPM_VSEL_LO = 5;
    localparam int BOPM_PROT_OFF_BIT = 2;
    localparam int BOPM_PSIZE_HI = 1;
    localparam int BOPM_PSIZE_LO = 0;
    localparam int BOPM_PINSEL_BIT = 0;
    localparam logic [7:0] BOPM_OPT_RESET = 8'hff;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] BOPM_REG_OPT = 8'h00;
    localparam logic [7:0] BOPM_REG_MAP = 8'h04;
    localparam logic [7:0] BOPM_REG_PIO = 8'h08;
    localparam logic [7:0] BOPM_REG_PGM = 8'h0c;
    localparam int BOPM_PIO_OUT_BIT = 0;
    localparam int BOPM_PIO_OE_BIT = 1;
    localparam int BOPM_PIO_IN_BIT = 2;
    localparam int BOPM_PGM_REF_BIT = 0;
    // ==========================================================
    // Register file sizes
    localparam int BOPM_RF_BYTES = 320;
    localparam int BOPM_DISP_BYTES = 22;
    localparam logic [7:0] BOPM_SET_BASE = 8'hc0;

    // Start address after reset for a vector select code
    function automatic logic [15:0] bopm_vec(input logic [1:0] sel);
        case (sel)
            2'b00: bopm_vec = 16'h0200;
            2'b01: bopm_vec = 16'h0300;
            2'b10: bopm_vec = 16'h0500;
            default: bopm_vec = 16'h0900;
        endcase
    endfunction
endpackage

// ==== src/bopm_optdec.sv ====
// Purpose: Decodes latched option bytes into reset vector, programming area and protection
// Assumes: Option bytes are stable after the loader finishes
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module bopm_optdec
    import bopm_pkg::*;
(
    input wire logic [7:0] i_opt3e,
    input wire logic [7:0] i_opt3f,
    output logic o_isp_en,
    output logic [15:0] o_reset_vec,
    output logic [15:0] o_isp_last,
    output logic o_prot_en,
    output logic [15:0] o_prot_last,
    output logic o_ext_reset_sel
);
    logic [1:0] vsel;
    logic [1:0] psel;
    assign vsel = i_opt3e[BOPM_VSEL_HI:BOPM_VSEL_LO];
    assign psel = i_opt3e[BOPM_PSIZE_HI:BOPM_PSIZE_LO];
    assign o_isp_en = ~i_opt3e[BOPM_ISP_OFF_BIT];
    assign o_reset_vec = o_isp_en ? bopm_vec(vsel) : BOPM_DEFAULT_VEC;
    assign o_isp_last = o_reset_vec - 16'h0001;
    assign o_prot_en = ~i_opt3e[BOPM_PROT_OFF_BIT];
    assign o_prot_last = bopm_vec(psel) - 16'h0001;
    assign o_ext_reset_sel = i_opt3f[BOPM_PINSEL_BIT];
endmodule // bopm_optdec
`default_nettype wire

// ==== src/bopm_regfile.sv ====
// Purpose: Core-facing 8-bit register file with mode-expanded upper area and display bytes
// Assumes: One access per cycle, read data one cycle later
// Notes:   Upper 64 bytes map to a separate 64-byte bank when i_set2 is set
`timescale 1ns/1ps
`default_nettype none
module bopm_regfile
    import bopm_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_set2,
    input wire logic i_disp,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:BOPM_RF_BYTES-1];
    logic [7:0] disp [0:BOPM_DISP_BYTES-1];
    logic [8:0] idx;
    logic disp_ok;
    assign idx = (i_set2 && i_addr >= BOPM_SET_BASE) ? {1'b1, 2'b00, i_addr[5:0]} : {1'b0, i_addr};
    assign disp_ok = {24'h0, i_addr} < BOPM_DISP_BYTES;

    always_ff @(posedge i_clock) begin
        if (i_we && !i_disp) begin
            mem[idx] <= i_wdata;
        end
        if (i_we && i_disp && disp_ok) begin
            disp[i_addr[4:0]] <= i_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_disp) begin
            o_rdata <= disp_ok ? disp[i_addr[4:0]] : 8'h00;
        end else begin
            o_rdata <= mem[idx];
        end
    end
endmodule // bopm_regfile
`default_nettype wire

// ==== src/bopm_top.sv ====
// Purpose: Boot option loader, program memory map and flash access gate
// Assumes: Flash returns i_flash_rdata one cycle after o_flash_addr
// Notes:   Core fetch is held off until the option bytes are latched
`timescale 1ns/1ps
`default_nettype none
module bopm_top
    import bopm_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Flash array
    output logic [13:0] o_flash_addr,
    input wire logic [7:0] i_flash_rdata,
    // Core fetch port
    input wire logic i_core_req,
    input wire logic [15:0] i_core_addr,
    output logic o_core_ready,
    output logic o_core_rvalid,
    output logic [7:0] o_core_rdata,
    output logic o_core_fault,
    output logic o_core_in_vec_area,
    output logic [15:0] o_reset_vec,
    output logic o_boot_done,
    // Store requests from program_memory_store_instr
    input wire logic i_pgm_req,
    input wire logic i_pgm_erase,
    input wire logic [15:0] i_pgm_addr,
    output logic o_pgm_accept,
    output logic o_pgm_refused,
    // Map status
    output logic o_isp_en,
    output logic [15:0] o_isp_last,
    output logic o_prot_en,
    // Shared pin
    input wire logic i_port0_bit2_io,
    output logic o_port0_bit2_io,
    output logic o_port0_bit2_io_oe,
    output logic o_pin_pullup_en,
    output logic o_ext_reset_in_n,
    // Register file bus
    input wire logic [7:0] i_rf_addr,
    input wire logic i_rf_set2,
    input wire logic i_rf_disp,
    input wire logic i_rf_we,
    input wire logic [7:0] i_rf_wdata,
    output logic [7:0] o_rf_rdata
);
    // ==========================================================
    // Option loader
    typedef enum logic [2:0] {
        BOPM_LD_START = 3'b000,
        BOPM_LD_WAIT3E = 3'b001,
        BOPM_LD_WAIT3F = 3'b010,
        BOPM_LD_DONE = 3'b011
    } bopm_ld_e;

    bopm_ld_e ld_state;
    bopm_ld_e next_ld_state;
    logic [7:0] opt3e;
    logic [7:0] opt3f;
    logic boot_done;

    always_comb begin
        case (ld_state)
            BOPM_LD_START: next_ld_state = BOPM_LD_WAIT3E;
            BOPM_LD_WAIT3E: next_ld_state = BOPM_LD_WAIT3F;
            BOPM_LD_WAIT3F: next_ld_state = BOPM_LD_DONE;
            BOPM_LD_DONE: next_ld_state = BOPM_LD_DONE;
            default: next_ld_state = BOPM_LD_START;
        endcase
    end

    // Flash answers a cycle late, so each byte lands one state after its address
    // latch once per reset
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ld_state <= BOPM_LD_START;
            opt3e <= BOPM_OPT_RESET;
            opt3f <= BOPM_OPT_RESET;
        end else begin
            ld_state <= next_ld_state;
            if (ld_state == BOPM_LD_WAIT3E) begin
                opt3e <= i_flash_rdata;
            end
            if (ld_state == BOPM_LD_WAIT3F) begin
                opt3f <= i_flash_rdata;
            end
        end
    end
    assign boot_done = (ld_state == BOPM_LD_DONE);
    assign o_boot_done = boot_done;

    // ==========================================================
    // Option decode
    logic isp_en;
    logic [15:0] reset_vec;
    logic [15:0] isp_last;
    logic prot_en;
    logic [15:0] prot_last;
    logic ext_reset_sel;

    bopm_optdec u_optdec (
        .i_opt3e(opt3e),
        .i_opt3f(opt3f),
        .o_isp_en(isp_en),
        .o_reset_vec(reset_vec),
        .o_isp_last(isp_last),
        .o_prot_en(prot_en),
        .o_prot_last(prot_last),
        .o_ext_reset_sel(ext_reset_sel)
    );
    assign o_reset_vec = boot_done ? reset_vec : BOPM_DEFAULT_VEC;
    assign o_isp_en = isp_en;
    assign o_isp_last = isp_last;
    assign o_prot_en = prot_en;

    // ==========================================================
    // Flash address and core fetch
    logic core_take;
    logic core_in_range;
    logic fetch_pend;
    logic fetch_fault;
    logic [13:0] ld_addr;

    assign core_in_range = i_core_addr < BOPM_FLASH_BYTES;
    assign o_core_ready = boot_done;
    assign core_take = i_core_req && boot_done;
    assign ld_addr = (ld_state == BOPM_LD_START) ? BOPM_OPT_ADDR_3E[13:0] : BOPM_OPT_ADDR_3F[13:0];
    assign o_flash_addr = boot_done ? i_core_addr[13:0] : ld_addr;
    assign o_core_in_vec_area = i_core_addr <= BOPM_VEC_AREA_LAST;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            fetch_pend <= 1'b0;
            fetch_fault <= 1'b0;
            o_core_rvalid <= 1'b0;
            o_core_rdata <= 8'h00;
            o_core_fault <= 1'b0;
        end else begin
            fetch_pend <= core_take;
            fetch_fault <= core_take && !core_in_range;
            o_core_rvalid <= fetch_pend;
            o_core_fault <= fetch_pend && fetch_fault;
            // Out of range fetches return ff together with the fault pulse
            if (fetch_pend) begin
                o_core_rdata <= fetch_fault ? 8'hff : i_flash_rdata;
            end
        end
    end

    // ==========================================================
    // Store gate
    logic pgm_in_prot;
    logic pgm_refuse;
    logic ref_flag;
    logic ref_clear;

    assign pgm_in_prot = i_pgm_addr >= BOPM_ISP_START && i_pgm_addr <= prot_last;
    assign pgm_refuse = i_pgm_req && (!boot_done || (prot_en && pgm_in_prot));

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_pgm_accept <= 1'b0;
            o_pgm_refused <= 1'b0;
            ref_flag <= 1'b0;
        end else begin
            o_pgm_accept <= i_pgm_req && !pgm_refuse;
            o_pgm_refused <= pgm_refuse;
            // A refusal in the clearing cycle wins over the clear
            ref_flag <= pgm_refuse | (ref_flag & ~ref_clear);
        end
    end

    // ==========================================================
    // Shared pin
    logic pio_out;
    logic pio_oe;

    assign o_pin_pullup_en = ext_reset_sel;
    assign o_ext_reset_in_n = ext_reset_sel ? i_port0_bit2_io : 1'b1;
    assign o_port0_bit2_io = pio_out;
    assign o_port0_bit2_io_oe = pio_oe && !ext_reset_sel;

    // ==========================================================
    // AHB-Lite slave
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic take_ap;
    logic wr_pio;
    logic [31:0] rd_mux;

    assign take_ap = i_hsel && i_htrans[1] && i_hready;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign wr_pio = ap_valid && ap_write && ap_addr == BOPM_REG_PIO;
    assign ref_clear = ap_valid && ap_write && ap_addr == BOPM_REG_PGM && i_hwdata[BOPM_PGM_REF_BIT];

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            ap_valid <= take_ap;
            ap_write <= i_hwrite;
            ap_addr <= {i_haddr[7:2], 2'b00};
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pio_out <= 1'b0;
            pio_oe <= 1'b0;
        end else if (wr_pio) begin
            pio_out <= i_hwdata[BOPM_PIO_OUT_BIT];
            pio_oe <= i_hwdata[BOPM_PIO_OE_BIT];
        end
    end

    always_comb begin
        case (ap_addr)
            BOPM_REG_OPT: rd_mux = {15'h0000, boot_done, opt3f, opt3e};
            BOPM_REG_MAP: rd_mux = {isp_last, reset_vec};
            BOPM_REG_PIO: rd_mux = {29'h0, i_port0_bit2_io, pio_oe, pio_out};
            BOPM_REG_PGM: rd_mux = {28'h0, ext_reset_sel, prot_en, isp_en, ref_flag};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign o_hrdata = (ap_valid && !ap_write) ? rd_mux : 32'h0000_0000;

    // ==========================================================
    // Register file
    // expanded register space
    bopm_regfile u_regfile (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_addr(i_rf_addr),
        .i_set2(i_rf_set2),
        .i_disp(i_rf_disp),
        .i_we(i_rf_we),
        .i_wdata(i_rf_wdata),
        .o_rdata(o_rf_rdata)
    );

    // ==========================================================
    // Checks
    a_boot_three_cycles: assert property (@(posedge i_clock)
        $rose(i_rst_n) |-> !boot_done [*3] ##1 boot_done)
        else $error("Option load did not finish three cycles after reset");
    a_options_stable: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        boot_done && $past(boot_done) |-> $stable(opt3e) && $stable(opt3f))
        else $error("Option bytes changed after load");
    a_default_vector: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        boot_done && opt3e[BOPM_ISP_OFF_BIT] |-> o_reset_vec == 16'h0100)
        else $error("Default vector not 0100h");
    a_isp_vector: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        boot_done && !opt3e[BOPM_ISP_OFF_BIT] && opt3e[6:5] == 2'b11 |-> o_reset_vec == 16'h0900
        && o_isp_last == 16'h08ff)
        else $error("Vector select 11 not 0900h");
    a_vsel_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        boot_done && !opt3e[7] && opt3e[6:5] == 2'b00 |-> o_reset_vec == 16'h0200)
        else $error("Vector select 00 not 0200h");
    a_prot_refuse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        boot_done && i_pgm_req && !opt3e[2] && i_pgm_addr == 16'h0100 |=> o_pgm_refused && !o_pgm_accept)
        else $error("Protected store not refused");
    a_prot_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        boot_done && i_pgm_req && opt3e[2] |=> o_pgm_accept)
        else $error("Store refused with protection off");
    a_fetch_latency: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        core_take |-> ##2 o_core_rvalid)
        else $error("Fetch answer not two cycles after request");
    a_fetch_range: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        core_take && i_core_addr >= 16'h4000 |-> ##2 o_core_fault)
        else $error("Out of range fetch not flagged");
    a_pin_select: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ext_reset_sel |-> o_pin_pullup_en && !o_port0_bit2_io_oe)
        else $error("Reset pin mode drives the pin");
    a_pin_port: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !ext_reset_sel |-> !o_pin_pullup_en && o_ext_reset_in_n)
        else $error("Port mode still acts as reset input");
    a_load_addr: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !boot_done |-> o_flash_addr == BOPM_OPT_ADDR_3E[13:0] || o_flash_addr == BOPM_OPT_ADDR_3F[13:0])
        else $error("Loader read outside the two option bytes");
    a_vec_stable: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        boot_done && $past(boot_done) |-> $stable(o_reset_vec))
        else $error("Reset vector changed after load");
    a_early_refuse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_pgm_req && !boot_done |=> o_pgm_refused)
        else $error("Store accepted before options were loaded");
    a_store_onehot: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !(o_pgm_accept && o_pgm_refused))
        else $error("Store both accepted and refused");
    a_fault_data: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_core_fault |-> o_core_rvalid && o_core_rdata == 8'hff)
        else $error("Out of range fetch answer malformed");

    // ==========================================================
    // Coverage
    c_boot_isp: cover property (@(posedge i_clock) disable iff (!i_rst_n) boot_done && isp_en);
    c_refused: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_pgm_refused);
    c_fetch: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_core_rvalid && !o_core_fault);
    c_erase_refused: cover property (@(posedge i_clock) disable iff (!i_rst_n)
        i_pgm_req && i_pgm_erase ##1 o_pgm_refused);
    c_pio_write: cover property (@(posedge i_clock) disable iff (!i_rst_n) wr_pio && i_hwdata[BOPM_PIO_OE_BIT]);
endmodule // bopm_top
`default_nettype wire

// ==== sim/bopm_flash_model.sv ====
// Purpose: Program flash array seen by the loader and the core fetch path
// Assumes: Data for an address returns one cycle later
// Notes:   Option bytes come from bench inputs so each boot can use new values
`timescale 1ns/1ps
`default_nettype none
module bopm_flash_model
    import bopm_pkg::*;
(
    input wire logic i_clock,
    input wire logic [13:0] i_addr,
    input wire logic [7:0] i_opt3e,
    input wire logic [7:0] i_opt3f,
    output logic [7:0] o_rdata
);
    // ==========================================================
    // Array contents
    // bench sets protection size within area
    always_ff @(posedge i_clock) begin
        if (i_addr == 14'h003e) begin
            o_rdata <= i_opt3e;
        end else if (i_addr == 14'h003f) begin
            o_rdata <= i_opt3f;
        end else begin
            o_rdata <= i_addr[7:0] ^ 8'h5a;
        end
    end
endmodule // bopm_flash_model
`default_nettype wire

// ==== sim/test_boot_option_and_program_map.sv ====
// Purpose: Self-checking bench for the boot option and program map block
// Assumes: Flash model answers one cycle after the address
// Notes:   The vector, store and pin scenarios reboot with their own option bytes; fetch and register file scenarios do not
`timescale 1ns/1ps
`default_nettype none
module test_boot_option_and_program_map;
    import bopm_pkg::*;
    logic i_clock, i_rst_n, i_hsel, i_hwrite, i_core_req, i_pgm_req, i_pgm_erase;
    logic i_rf_set2, i_rf_disp, i_rf_we, pin_ext, i_port0_bit2_io;
    logic [31:0] i_haddr, i_hwdata, o_hrdata;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic o_hreadyout, o_hresp, o_core_ready, o_core_rvalid, o_core_fault, o_core_in_vec_area, o_boot_done;
    logic o_pgm_accept, o_pgm_refused, o_isp_en, o_prot_en, o_port0_bit2_io, o_port0_bit2_io_oe;
    logic o_pin_pullup_en, o_ext_reset_in_n;
    logic [13:0] o_flash_addr;
    logic [7:0] i_flash_rdata, o_core_rdata, i_rf_addr, i_rf_wdata, o_rf_rdata, opt3e, opt3f;
    logic [15:0] i_core_addr, o_reset_vec, i_pgm_addr, o_isp_last;
    logic [31:0] rd;
    int err_count, comparisons;
    assign i_port0_bit2_io = o_port0_bit2_io_oe ? o_port0_bit2_io : pin_ext;
    bopm_top u_bopm_top (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_flash_addr(o_flash_addr), .i_flash_rdata(i_flash_rdata), .i_core_req(i_core_req),
        .i_core_addr(i_core_addr), .o_core_ready(o_core_ready), .o_core_rvalid(o_core_rvalid),
        .o_core_rdata(o_core_rdata), .o_core_fault(o_core_fault), .o_core_in_vec_area(o_core_in_vec_area),
        .o_reset_vec(o_reset_vec), .o_boot_done(o_boot_done), .i_pgm_req(i_pgm_req), .i_pgm_erase(i_pgm_erase),
        .i_pgm_addr(i_pgm_addr), .o_pgm_accept(o_pgm_accept), .o_pgm_refused(o_pgm_refused),
        .o_isp_en(o_isp_en), .o_isp_last(o_isp_last), .o_prot_en(o_prot_en),
        .i_port0_bit2_io(i_port0_bit2_io), .o_port0_bit2_io(o_port0_bit2_io),
        .o_port0_bit2_io_oe(o_port0_bit2_io_oe), .o_pin_pullup_en(o_pin_pullup_en),
        .o_ext_reset_in_n(o_ext_reset_in_n), .i_rf_addr(i_rf_addr), .i_rf_set2(i_rf_set2),
        .i_rf_disp(i_rf_disp), .i_rf_we(i_rf_we), .i_rf_wdata(i_rf_wdata), .o_rf_rdata(o_rf_rdata));
    bopm_flash_model u_bopm_flash_model (.i_clock(i_clock), .i_addr(o_flash_addr), .i_opt3e(opt3e),
        .i_opt3f(opt3f), .o_rdata(i_flash_rdata));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // ==========================================================
    // Shared tasks
    task automatic print_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic timeout();
        err_count++;
        print_verdict();
    endtask
    task automatic boot(input logic [7:0] e, input logic [7:0] f);
        int n;
        opt3e <= e;
        opt3f <= f;
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_clock);
        #1;
        chk("vec_in_reset", o_reset_vec, 32'h0100);
        @(posedge i_clock);
        i_rst_n <= 1'b1;
        i_pgm_req <= 1'b1;
        #1;
        chk("ready_early", o_core_ready, 32'h0);
        @(posedge i_clock);
        i_pgm_req <= 1'b0;
        #1;
        chk("early_store", o_pgm_refused, 32'h1);
        for (n = 1; n < 12 && o_boot_done !== 1'b1; n++) begin
            @(posedge i_clock);
            #1;
        end
        if (o_boot_done !== 1'b1) timeout();
        chk("boot_cycles", n, 32'h3);
        chk("ready_done", o_core_ready, 32'h1);
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        logic rdy;
        @(posedge i_clock);
        i_hsel <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr <= a;
        i_hwrite <= w;
        i_hsize <= 3'b010;
        for (int p = 0; p < 2; p++) begin
            rdy = 1'b0;
            for (n = 0; n < 20 && !rdy; n++) begin
                @(posedge i_clock);
                rdy = (o_hreadyout === 1'b1);
            end
            if (!rdy) timeout();
            chk("hresp", o_hresp, 32'h0);
            if (p == 0) begin
                i_htrans <= 2'b00;
                i_hsel <= 1'b0;
                i_hwdata <= d;
            end else begin
                r = o_hrdata;
            end
        end
    endtask
    task automatic fetch(input logic [15:0] a, input logic [7:0] exp, input logic flt);
        int n;
        @(posedge i_clock);
        i_core_req <= 1'b1;
        i_core_addr <= a;
        #1;
        chk("vec_area", o_core_in_vec_area, {31'h0, a <= 16'h00ff});
        @(posedge i_clock);
        i_core_req <= 1'b0;
        for (n = 0; n < 3 && o_core_rvalid !== 1'b1; n++) begin
            @(posedge i_clock);
            #1;
        end
        if (o_core_rvalid !== 1'b1) timeout();
        chk("rvalid", o_core_rvalid, 32'h1);
        chk("fetch_data", o_core_rdata, exp);
        chk("fault", o_core_fault, {31'h0, flt});
    endtask
    task automatic store(input logic [15:0] a, input logic er, input logic refused);
        @(posedge i_clock);
        i_pgm_req <= 1'b1;
        i_pgm_erase <= er;
        i_pgm_addr <= a;
        @(posedge i_clock);
        i_pgm_req <= 1'b0;
        #1;
        chk("refused", o_pgm_refused, {31'h0, refused});
        chk("accept", o_pgm_accept, {31'h0, !refused});
    endtask
    task automatic rf(input logic [7:0] a, input logic s2, input logic dp, input logic we, input logic [7:0] d);
        @(posedge i_clock);
        i_rf_addr <= a;
        i_rf_set2 <= s2;
        i_rf_disp <= dp;
        i_rf_we <= we;
        i_rf_wdata <= d;
        @(posedge i_clock);
        i_rf_we <= 1'b0;
        #1;
        if (!we) chk("rf_rdata", o_rf_rdata, d);
    endtask
    // ==========================================================
    // Scenarios
    task automatic test_vectors();
        logic [15:0] v;
        boot(8'hff, 8'h01);
        chk("vec_default", o_reset_vec, 32'h0100);
        chk("isp_off", o_isp_en, 32'h0);
        for (int s = 0; s < 4; s++) begin
            boot({1'b0, s[1:0], 5'h1f}, 8'h01);
            v = (s == 0) ? 16'h0200 : (s == 1) ? 16'h0300 : (s == 2) ? 16'h0500 : 16'h0900;
            chk("vec_sel", o_reset_vec, v);
            chk("isp_last", o_isp_last, v - 16'h1);
            chk("isp_on", o_isp_en, 32'h1);
        end
        boot(8'he4, 8'h01);
        chk("vsel_ignored", o_reset_vec, 32'h0100);
    endtask
    task automatic test_fetch();
        fetch(16'h0010, 8'h4a, 1'b0);
        fetch(16'h003e, 8'he4, 1'b0);
        fetch(16'h3fff, 8'ha5, 1'b0);
        fetch(16'h4000, 8'hff, 1'b1);
    endtask
    task automatic test_store();
        boot(8'h18, 8'h01);
        chk("prot_en", o_prot_en, 32'h1);
        store(16'h0100, 1'b1, 1'b1);
        store(16'h01ff, 1'b0, 1'b1);
        store(16'h0200, 1'b0, 1'b0);
        store(16'h00ff, 1'b1, 1'b0);
        store(16'h003e, 1'b0, 1'b0);
        chk("vec_kept", o_reset_vec, 32'h0200);
        ahb(1'b0, 32'h0000000c, 32'h0, rd);
        chk("pgm_reg", rd[3:0], 32'hf);
        ahb(1'b1, 32'h0000000c, 32'h1, rd);
        ahb(1'b0, 32'h0000000c, 32'h0, rd);
        chk("pgm_clear", rd[3:0], 32'he);
        boot(8'h1c, 8'h01);
        chk("prot_off", o_prot_en, 32'h0);
        store(16'h0100, 1'b1, 1'b0);
    endtask
    task automatic test_pin();
        boot(8'hff, 8'h01);
        pin_ext <= 1'b0;
        #1;
        chk("pullup_on", o_pin_pullup_en, 32'h1);
        chk("ext_reset_low", o_ext_reset_in_n, 32'h0);
        chk("oe_off", o_port0_bit2_io_oe, 32'h0);
        boot(8'hff, 8'h00);
        chk("pullup_off", o_pin_pullup_en, 32'h0);
        chk("ext_reset_idle", o_ext_reset_in_n, 32'h1);
        ahb(1'b1, 32'h00000008, 32'h3, rd);
        ahb(1'b0, 32'h00000008, 32'h0, rd);
        chk("pio_reg", rd, 32'h7);
        chk("pin_oe", o_port0_bit2_io_oe, 32'h1);
        ahb(1'b0, 32'h00000000, 32'h0, rd);
        chk("opt_reg", rd, 32'h000100ff);
        ahb(1'b1, 32'h00000040, 32'hffffffff, rd);
        ahb(1'b0, 32'h00000040, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
    endtask
    task automatic test_rf();
        rf(8'h10, 1'b0, 1'b0, 1'b1, 8'ha5);
        rf(8'hc0, 1'b0, 1'b0, 1'b1, 8'h11);
        rf(8'hc0, 1'b1, 1'b0, 1'b1, 8'h22);
        rf(8'h05, 1'b0, 1'b1, 1'b1, 8'h33);
        rf(8'h10, 1'b0, 1'b0, 1'b0, 8'ha5);
        rf(8'hc0, 1'b0, 1'b0, 1'b0, 8'h11);
        rf(8'hc0, 1'b1, 1'b0, 1'b0, 8'h22);
        rf(8'h05, 1'b0, 1'b1, 1'b0, 8'h33);
        rf(8'h20, 1'b0, 1'b1, 1'b0, 8'h00);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        err_count = 0;
        comparisons = 0;
        {i_rst_n, i_hsel, i_hwrite, i_core_req, i_pgm_req, i_pgm_erase} = 6'h0;
        {i_rf_set2, i_rf_disp, i_rf_we} = 3'h0;
        pin_ext = 1'b1;
        i_haddr = 32'h0;
        i_hwdata = 32'h0;
        i_htrans = 2'b00;
        i_hsize = 3'b010;
        i_core_addr = 16'h0;
        i_pgm_addr = 16'h0;
        i_rf_addr = 8'h0;
        i_rf_wdata = 8'h0;
        opt3e = 8'hff;
        opt3f = 8'h01;
        test_vectors();
        test_fetch();
        test_store();
        test_pin();
        test_rf();
        print_verdict();
    end
endmodule // test_boot_option_and_program_map
`default_nettype wire
